/* hw/opm_cfg.svh */
`ifndef OPM_CFG_SVH
`define OPM_CFG_SVH
// apb register byte offsets
`define OPM_A_CTRL      12'h000
`define OPM_A_GAIN      12'h004
`define OPM_A_OFFSET    12'h008
`define OPM_A_BGCOL     12'h00C
`define OPM_A_VIDALPHA  12'h010
`define OPM_A_CURPOS    12'h014
`define OPM_A_CURSIZE   12'h018
`define OPM_A_CLIPMIN   12'h01C
`define OPM_A_CLIPMAX   12'h020
`define OPM_A_CURPTR    12'h024
`define OPM_A_CURPITCH  12'h028
`define OPM_A_GFXGAIN   12'h02C
`define OPM_A_CURPAL    12'h030
`define OPM_A_STATUS    12'h034
// alpha scale
`define OPM_ALPHA_FULL  9'h080
`define OPM_CUR_MAX     8'h80
`define OPM_GFX_UNITY   8'h80
`endif

/* hw/opm_pkg.sv */
package opm_pkg;
	typedef enum logic [1:0] {
		OPM_PIXEL   = 2'h0,
		OPM_GLOBAL  = 2'h1,
		OPM_PROP    = 2'h2,
		OPM_NOBLEND = 2'h3
	} opm_mode_t;
endpackage : opm_pkg

/* hw/opm_mixer.sv */
// Summary of operation
// - two-bit mode picks pixel, global, proportional or no blending for the whole frame
// - pixel mode uses only the palette alpha as blend factor
// - global mode uses the region weight for all pixels, ignoring palette alpha
// - proportional: gain bit8 set multiplies alpha, else divides by gain/128
// - no-blending mode shows the osd pixel fully opaque over video
// - alpha spans 0..128; stored values above 80h clamp to 80h
// - region weight above 80h clamps to 80h, used only in global mode
// - a ten-bit offset is added to the osd rgb outputs
// - compositor merges background, video, cursor and osd planes into one stream
// - planes blend with factor 0..128: 129 transparency levels, except 16 for the cursor
// - background is an opaque 24-bit rgb colour seen through transparent planes
// - video over background with video alpha gives contrast independent of osd
// - video is ycbcr 4:4:4 ten-bit, one global alpha, 601 to rgb conversion
// - cursor uses 8-bit indices into argb4444 palette, up to 128x128, 4-bit alpha
// - cursor pixels outside the clipping window are transparent
// - cursor bitmap fetched via programmable pointer and line pitch
// - graphics pixels argb 8:10:10:10 get gain and offset before composition
`timescale 1ns/1ps
`include "opm_cfg.svh"
module opm_mixer (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// video plane, ycbcr 4:4:4
	input  wire logic        vid_valid,
	input  wire logic [9:0]  vid_y,
	input  wire logic [9:0]  vid_cb,
	input  wire logic [9:0]  vid_cr,
	input  wire logic [11:0] pix_x,
	input  wire logic [10:0] pix_y,
	// osd plane, palette entry of current pixel
	input  wire logic        osd_valid,
	input  wire logic [7:0]  osd_r,
	input  wire logic [7:0]  osd_g,
	input  wire logic [7:0]  osd_b,
	input  wire logic [7:0]  osd_alpha,
	// graphics plane, argb 8:10:10:10
	input  wire logic        gfx_valid,
	input  wire logic [37:0] gfx_argb,
	// cursor fetch
	input  wire logic [7:0]  cur_index,
	output logic      [31:0] cur_fetch_addr,
	// composited rgb out
	output logic             out_valid,
	output logic      [9:0]  out_r,
	output logic      [9:0]  out_g,
	output logic      [9:0]  out_b
);
	logic [31:0] ctrl_r, gain_r, offset_r, bg_r, valpha_r, curpos_r, cursize_r;
	logic [31:0] clipmin_r, clipmax_r, curptr_r, curpitch_r, gfxgain_r;
	logic [15:0] curpal_r [0:255];
	logic        ovf_r;

	// apb decode; zero-wait-state slave
	wire         acc   = psel & penable;
	wire         wr_en = acc & pwrite;
	wire         pal_hit = paddr[11:10] == 2'h1;
	wire         known = (paddr <= `OPM_A_STATUS) | pal_hit;
	logic [31:0] rd_mux;
	always_comb begin
		unique case (paddr)
			`OPM_A_CTRL:     rd_mux = ctrl_r;
			`OPM_A_GAIN:     rd_mux = gain_r;
			`OPM_A_OFFSET:   rd_mux = offset_r;
			`OPM_A_BGCOL:    rd_mux = bg_r;
			`OPM_A_VIDALPHA: rd_mux = valpha_r;
			`OPM_A_CURPOS:   rd_mux = curpos_r;
			`OPM_A_CURSIZE:  rd_mux = cursize_r;
			`OPM_A_CLIPMIN:  rd_mux = clipmin_r;
			`OPM_A_CLIPMAX:  rd_mux = clipmax_r;
			`OPM_A_CURPTR:   rd_mux = curptr_r;
			`OPM_A_CURPITCH: rd_mux = curpitch_r;
			`OPM_A_GFXGAIN:  rd_mux = gfxgain_r;
			`OPM_A_STATUS:   rd_mux = {31'h0, ovf_r};
			default:         rd_mux = pal_hit ? {16'h0, curpal_r[paddr[9:2]]} : 32'h0;
		endcase
	end

	// one hit wire per register keeps each write block to a single compare
	wire         hit_ctrl     = paddr == `OPM_A_CTRL;
	wire         hit_gain     = paddr == `OPM_A_GAIN;
	wire         hit_offset   = paddr == `OPM_A_OFFSET;
	wire         hit_bg       = paddr == `OPM_A_BGCOL;
	wire         hit_valpha   = paddr == `OPM_A_VIDALPHA;
	wire         hit_curpos   = paddr == `OPM_A_CURPOS;
	wire         hit_cursize  = paddr == `OPM_A_CURSIZE;
	wire         hit_clipmin  = paddr == `OPM_A_CLIPMIN;
	wire         hit_clipmax  = paddr == `OPM_A_CLIPMAX;
	wire         hit_curptr   = paddr == `OPM_A_CURPTR;
	wire         hit_curpitch = paddr == `OPM_A_CURPITCH;
	wire         hit_gfxgain  = paddr == `OPM_A_GFXGAIN;
	wire         setup_ph     = psel & ~penable;

	// pready one cycle after setup gives a zero-wait access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~known;
			prdata  <= (setup_ph & ~pwrite) ? rd_mux : prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 32'h0;
		end else if (wr_en & hit_ctrl) begin
			ctrl_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_r <= 32'h0;
		end else if (wr_en & hit_gain) begin
			gain_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offset_r <= 32'h0;
		end else if (wr_en & hit_offset) begin
			offset_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bg_r <= 32'h0;
		end else if (wr_en & hit_bg) begin
			bg_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valpha_r <= 32'h0;
		end else if (wr_en & hit_valpha) begin
			valpha_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			curpos_r <= 32'h0;
		end else if (wr_en & hit_curpos) begin
			curpos_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cursize_r <= 32'h0;
		end else if (wr_en & hit_cursize) begin
			cursize_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clipmin_r <= 32'h0;
		end else if (wr_en & hit_clipmin) begin
			clipmin_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clipmax_r <= 32'h0;
		end else if (wr_en & hit_clipmax) begin
			clipmax_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			curptr_r <= 32'h0;
		end else if (wr_en & hit_curptr) begin
			curptr_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			curpitch_r <= 32'h0;
		end else if (wr_en & hit_curpitch) begin
			curpitch_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gfxgain_r <= 32'h0;
		end else if (wr_en & hit_gfxgain) begin
			gfxgain_r <= pwdata;
		end
	end

	// palette array has no reset; software loads it before enabling the cursor
	always_ff @(posedge pclk) begin
		if (wr_en & pal_hit)
			curpal_r[paddr[9:2]] <= pwdata[15:0];
	end

	// control fields
	opm_pkg::opm_mode_t blend_mode_select;
	assign blend_mode_select = opm_pkg::opm_mode_t'(ctrl_r[1:0]);
	wire        cur_en             = ctrl_r[2];
	wire [7:0]  region_blend_weight = ctrl_r[15:8];
	wire [8:0]  blend_gain          = gain_r[8:0];
	wire        blend_gain_multiply_flag = blend_gain[8];
	wire [9:0]  osd_offset = offset_r[9:0];

	// clamp helpers
	function automatic logic [8:0] sat128(input logic [15:0] v);
		sat128 = (v > 16'(`OPM_ALPHA_FULL)) ? `OPM_ALPHA_FULL : v[8:0];
	endfunction : sat128

	wire [8:0]  alpha_c  = sat128({8'h0, osd_alpha});
	wire [8:0]  weight_c = sat128({8'h0, region_blend_weight});
	// divide by gain/128 == alpha*128/gain; zero gain saturates to full
	wire [15:0] prop_mul = 16'(alpha_c) * 16'(blend_gain[7:0]);
	wire [15:0] prop_div = (blend_gain[7:0] == 8'h0) ? 16'hFFFF :
		16'((16'(alpha_c) << 7) / 16'(blend_gain[7:0]));
	wire [8:0]  prop_f = sat128(blend_gain_multiply_flag ? prop_mul : prop_div);

	logic [8:0] osd_f;
	always_comb begin
		unique case (blend_mode_select)
			opm_pkg::OPM_PIXEL:   osd_f = alpha_c;
			opm_pkg::OPM_GLOBAL:  osd_f = weight_c;
			opm_pkg::OPM_PROP:    osd_f = prop_f;
			opm_pkg::OPM_NOBLEND: osd_f = `OPM_ALPHA_FULL;
		endcase
	end

	// blend of two ten-bit values with factor 0..128
	function automatic logic [9:0] mix(input logic [8:0] f, input logic [9:0] top, input logic [9:0] bot);
		logic [18:0] s;
		s = 19'(f) * 19'(top) + 19'(9'h080 - f) * 19'(bot);
		mix = s[16:7];
	endfunction : mix

	// 601 ycbcr to rgb, coefficients in 1/256
	function automatic logic [9:0] clip10(input logic signed [20:0] v);
		clip10 = (v < 0) ? 10'h0 : (v > 21'sh3FF) ? 10'h3FF : v[9:0];
	endfunction : clip10
	wire signed [20:0] yy = 21'sd298 * $signed({11'h0, vid_y} - 21'sd64);
	wire signed [20:0] cb = $signed({11'h0, vid_cb}) - 21'sd512;
	wire signed [20:0] cr = $signed({11'h0, vid_cr}) - 21'sd512;
	wire [9:0] vr = clip10(21'((yy + 21'sd409 * cr) >>> 8));
	wire [9:0] vg = clip10(21'((yy - 21'sd100 * cb - 21'sd208 * cr) >>> 8));
	wire [9:0] vb = clip10(21'((yy + 21'sd516 * cb) >>> 8));

	// background 24-bit colour widened to ten bits
	wire [9:0] bgr = {bg_r[23:16], 2'h0};
	wire [9:0] bgg = {bg_r[15:8], 2'h0};
	wire [9:0] bgb = {bg_r[7:0], 2'h0};
	// video over background with global alpha; 256 levels mapped to 0..128
	wire [8:0] vid_f = vid_valid ? 9'((9'(valpha_r[7:0]) + 9'h001) >> 1) : 9'h0;
	wire [9:0] l1r = mix(vid_f, vr, bgr);
	wire [9:0] l1g = mix(vid_f, vg, bgg);
	wire [9:0] l1b = mix(vid_f, vb, bgb);

	// graphics gain (unity 80h) and offset
	function automatic logic [9:0] gfx_adj(input logic [9:0] c, input logic [7:0] g, input logic [9:0] o);
		logic [19:0] p;
		p = ((20'(c) * 20'(g)) >> 7) + 20'(o);
		gfx_adj = (p > 20'h3FF) ? 10'h3FF : p[9:0];
	endfunction : gfx_adj
	wire [8:0] gfx_f = gfx_valid ? 9'((9'(gfx_argb[37:30]) + 9'h001) >> 1) : 9'h0;
	wire [9:0] gr = gfx_adj(gfx_argb[29:20], gfxgain_r[7:0], gfxgain_r[25:16]);
	wire [9:0] gg = gfx_adj(gfx_argb[19:10], gfxgain_r[7:0], gfxgain_r[25:16]);
	wire [9:0] gb = gfx_adj(gfx_argb[9:0],   gfxgain_r[7:0], gfxgain_r[25:16]);
	wire [9:0] l2r = mix(gfx_f, gr, l1r);
	wire [9:0] l2g = mix(gfx_f, gg, l1g);
	wire [9:0] l2b = mix(gfx_f, gb, l1b);

	// osd plane with offset
	function automatic logic [9:0] add_off(input logic [7:0] c, input logic [9:0] o);
		logic [10:0] s;
		s = 11'({c, 2'h0}) + 11'(o);
		add_off = s[10] ? 10'h3FF : s[9:0];
	endfunction : add_off
	wire [8:0] osd_fv = osd_valid ? osd_f : 9'h0;
	wire [9:0] l3r = mix(osd_fv, add_off(osd_r, osd_offset), l2r);
	wire [9:0] l3g = mix(osd_fv, add_off(osd_g, osd_offset), l2g);
	wire [9:0] l3b = mix(osd_fv, add_off(osd_b, osd_offset), l2b);

	// cursor: position, size up to 128, clip window
	wire [11:0] cx = pix_x - curpos_r[11:0];
	wire [10:0] cy = pix_y - curpos_r[26:16];
	wire [7:0]  cw = (cursize_r[7:0] > `OPM_CUR_MAX) ? `OPM_CUR_MAX : cursize_r[7:0];
	wire [7:0]  ch = (cursize_r[23:16] > `OPM_CUR_MAX) ? `OPM_CUR_MAX : cursize_r[23:16];
	wire        in_cur = (pix_x >= curpos_r[11:0]) & (pix_y >= curpos_r[26:16]) &
		(cx < 12'(cw)) & (cy < 11'(ch));
	wire        in_clip = (pix_x >= clipmin_r[11:0]) & (pix_x <= clipmax_r[11:0]) &
		(pix_y >= clipmin_r[26:16]) & (pix_y <= clipmax_r[26:16]);
	wire        cur_show = cur_en & in_cur & in_clip;
	wire [15:0] cpal = curpal_r[cur_index];
	// 4-bit alpha to 0..128 for antialiased edges
	// top alpha code is fully opaque; unloaded palette entries must not leak unknowns
	wire        cur_opq = cpal[15:12] == 4'hF;
	wire [8:0]  cur_f = ~cur_show ? 9'h0 : cur_opq ? `OPM_ALPHA_FULL : 9'({cpal[15:12], 3'h0});
	wire [9:0]  l4r = cur_show ? mix(cur_f, {cpal[11:8], cpal[11:8], cpal[11:10]}, l3r) : l3r;
	wire [9:0]  l4g = cur_show ? mix(cur_f, {cpal[7:4], cpal[7:4], cpal[7:6]}, l3g) : l3g;
	wire [9:0]  l4b = cur_show ? mix(cur_f, {cpal[3:0], cpal[3:0], cpal[3:2]}, l3b) : l3b;
	// fetch address of the cursor pixel one line ahead is left to the memory side
	wire [31:0] fetch_nxt = curptr_r + 32'(cy[6:0]) * curpitch_r[15:0] + 32'(cx[6:0]);

	// output register; one cycle latency
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid      <= 1'b0;
			out_r          <= 10'h0;
			out_g          <= 10'h0;
			out_b          <= 10'h0;
			cur_fetch_addr <= 32'h0;
			ovf_r          <= 1'b0;
		end else begin
			out_valid      <= vid_valid | osd_valid | gfx_valid;
			out_r          <= l4r;
			out_g          <= l4g;
			out_b          <= l4b;
			cur_fetch_addr <= fetch_nxt;
			ovf_r          <= blend_gain_multiply_flag & (prop_mul > 16'(`OPM_ALPHA_FULL));
		end
	end
endmodule : opm_mixer

/* sim/opm_mix_monitor.sv */
`timescale 1ns/1ps
`include "opm_cfg.svh"
module opm_mix_monitor (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pixels
	input wire logic        osd_valid,
	input wire logic [7:0]  osd_r,
	input wire logic [7:0]  osd_alpha,
	input wire logic [9:0]  out_r
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] ctrl_r;
	logic [9:0]  off_r;
	wire         wr_ok = psel & penable & pready & pwrite;
	// only opaque cases are judged: a cursor or an offset would change the result
	wire         top_ok = osd_valid & ~ctrl_r[2] & (off_r == 10'h000);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 16'h0000;
			off_r  <= 10'h000;
		end else if (wr_ok && paddr == `OPM_A_CTRL) begin
			ctrl_r <= pwdata[15:0];
		end else if (wr_ok && paddr == `OPM_A_OFFSET) begin
			off_r <= pwdata[9:0];
		end
	end
	setup_answer_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
	err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	hole_refused_a: assert property (psel && !penable && !pwrite && paddr > 12'h034 && paddr < 12'h400
		|=> pslverr && prdata == 32'h0) else $error("unmapped read accepted");
	noblend_full_a: assert property (top_ok && ctrl_r[1:0] == 2'h3 |=> out_r == {$past(osd_r), 2'h0})
		else $error("no-blend pixel not opaque");
	alpha_clamp_a: assert property (top_ok && ctrl_r[1:0] == 2'h0 && osd_alpha > 8'h80
		|=> out_r == {$past(osd_r), 2'h0}) else $error("alpha not clamped");
	weight_clamp_a: assert property (top_ok && ctrl_r[1:0] == 2'h1 && ctrl_r[15:8] > 8'h80
		|=> out_r == {$past(osd_r), 2'h0}) else $error("weight not clamped");
	cover property (wr_ok && paddr == `OPM_A_GAIN);
	cover property (pslverr);
	cover property (top_ok && ctrl_r[1:0] == 2'h2);
endmodule : opm_mix_monitor
bind opm_mixer opm_mix_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .osd_valid, .osd_r, .osd_alpha, .out_r);

/* sim/opm_pix_src.sv */
`timescale 1ns/1ps
module opm_pix_src (
	// clock
	input wire logic        pclk,
	// video plane
	output logic            vid_valid,
	output logic     [9:0]  vid_y,
	output logic     [9:0]  vid_cb,
	output logic     [9:0]  vid_cr,
	output logic     [11:0] pix_x,
	output logic     [10:0] pix_y,
	// osd, graphics, cursor
	output logic            osd_valid,
	output logic     [7:0]  osd_r,
	output logic     [7:0]  osd_g,
	output logic     [7:0]  osd_b,
	output logic     [7:0]  osd_alpha,
	output logic            gfx_valid,
	output logic     [37:0] gfx_argb,
	output logic     [7:0]  cur_index
);
	initial begin
		{vid_valid, osd_valid, gfx_valid} = 3'h0;
		{vid_y, vid_cb, vid_cr} = 30'h2AAAAAAA;
		{pix_x, pix_y, cur_index} = 31'h0;
		{osd_r, osd_g, osd_b, osd_alpha} = 32'h0;
		gfx_argb = 38'h0;
	end
	// idle cycles carry inverted osd data so a stale osd pixel never looks current
	task send(input logic [7:0] c, input logic [7:0] a);
		@(posedge pclk);
		{vid_valid, osd_valid} <= 2'h3;
		{osd_r, osd_g, osd_b, osd_alpha} <= {c, c, c, a};
		{vid_y, vid_cb, vid_cr} <= ~{vid_y, vid_cb, vid_cr};
		pix_x <= pix_x + 12'h001;
		cur_index <= cur_index + 8'h01;
		gfx_argb <= ~gfx_argb;
		@(posedge pclk);
		{vid_valid, osd_valid} <= 2'h0;
		{osd_r, osd_g, osd_b, osd_alpha} <= ~{c, c, c, a};
	endtask : send
endmodule : opm_pix_src

/* sim/osd_video_plane_mixer_bench.sv */
`timescale 1ns/1ps
`include "opm_cfg.svh"
module osd_video_plane_mixer_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        vid_valid, osd_valid, gfx_valid, out_valid;
	logic [11:0] paddr, pix_x;
	logic [10:0] pix_y;
	logic [31:0] pwdata, prdata, cur_fetch_addr, rd;
	logic [9:0]  vid_y, vid_cb, vid_cr, out_r, out_g, out_b;
	logic [7:0]  osd_r, osd_g, osd_b, osd_alpha, cur_index;
	logic [37:0] gfx_argb;
	int          err_total, total_checks;
	// rows: mode, weight, gain, palette alpha, resulting factor
	logic [1:0]  md [9] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2, 2'h2};
	logic [7:0]  wt [9] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h90, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [8:0]  gn [9] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h040, 9'h102, 9'h102};
	logic [7:0]  al [9] = '{8'h40, 8'hC0, 8'h00, 8'h70, 8'h10, 8'h00, 8'h20, 8'h30, 8'h50};
	logic [7:0]  fx [9] = '{8'h40, 8'h80, 8'h00, 8'h20, 8'h80, 8'h80, 8'h40, 8'h60, 8'h80};
	opm_mixer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.vid_valid, .vid_y, .vid_cb, .vid_cr, .pix_x, .pix_y, .osd_valid, .osd_r, .osd_g, .osd_b,
		.osd_alpha, .gfx_valid, .gfx_argb, .cur_index, .cur_fetch_addr, .out_valid, .out_r, .out_g, .out_b);
	opm_pix_src src_u (.pclk, .vid_valid, .vid_y, .vid_cb, .vid_cr, .pix_x, .pix_y, .osd_valid, .osd_r,
		.osd_g, .osd_b, .osd_alpha, .gfx_valid, .gfx_argb, .cur_index);
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			err_total++;
			end_sim;
		end
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb
	// background 20h widened to 080h, osd C8h widened to 320h
	function automatic logic [9:0] mix(input logic [7:0] f);
		mix = 10'((32'(f) * 32'h320 + (32'h80 - 32'(f)) * 32'h80) >> 7);
	endfunction : mix
	task px(input logic [7:0] a, input logic [9:0] e);
		src_u.send(8'hC8, a);
		#1;
		chk({22'h0, out_r}, {22'h0, e});
		chk({22'h0, out_g}, {22'h0, e});
		chk({22'h0, out_b}, {22'h0, e});
		chk({31'h0, out_valid}, 32'h1);
	endtask : px
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
		err_total = 0;
		total_checks = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, `OPM_A_BGCOL, 32'h00202020);
		apb(1'b0, `OPM_A_BGCOL, 32'h0);
		chk(rd, 32'h00202020);
		// video made fully transparent so only background lies under the osd
		apb(1'b1, `OPM_A_VIDALPHA, 32'h0);
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, `OPM_A_CTRL, {16'h0, wt[i], 6'h0, md[i]});
			apb(1'b1, `OPM_A_GAIN, {23'h0, gn[i]});
			px(al[i], mix(fx[i]));
		end
		apb(1'b0, `OPM_A_STATUS, 32'h0);
		chk({31'h0, rd[0]}, 32'h1);
		$display("blend modes done");
		apb(1'b1, `OPM_A_CTRL, 32'h3);
		apb(1'b1, `OPM_A_OFFSET, 32'h10);
		px(8'h00, 10'h330);
		apb(1'b1, `OPM_A_CURSIZE, 32'h00FF00FF);
		apb(1'b0, `OPM_A_CURSIZE, 32'h0);
		chk(rd, 32'h00FF00FF);
		apb(1'b1, `OPM_A_CURPTR, 32'h00001000);
		px(8'h00, 10'h330);
		chk(cur_fetch_addr, 32'h0000100B);
		apb(1'b1, 12'h400, 32'h0000ABCD);
		apb(1'b0, 12'h400, 32'h0);
		chk(rd, 32'h0000ABCD);
		apb(1'b0, 12'h100, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("registers done");
		end_sim;
	end
endmodule : osd_video_plane_mixer_bench
